// [design/core_exec.sv]
// Execution unit for shift, flag, transfer and core control instructions.
// Assumes synchronous byte memories answering one cycle after a read strobe,
// I/O space answering within the same cycle, and an Avalon-MM master.
`timescale 1ns/1ns
`include "core_exec_params.svh"
module core_exec
  import core_exec_pkg::*;
#(
  parameter int NREG = 32
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  // Avalon-MM register slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Data memory
  output logic      [15:0] dm_addr_o,
  output logic      [7:0]  dm_wdata_o,
  output logic             dm_re_o,
  output logic             dm_we_o,
  input  wire logic [7:0]  dm_rdata_i,
  // Program memory
  output logic      [15:0] pm_addr_o,
  output logic             pm_re_o,
  input  wire logic [7:0]  pm_rdata_i,
  // I/O space
  output logic      [5:0]  io_addr_o,
  output logic      [7:0]  io_wdata_o,
  output logic             io_re_o,
  output logic             io_we_o,
  input  wire logic [7:0]  io_rdata_i,
  // Core control
  output logic             busy_o,
  output logic             sleep_req_o,
  output logic      [1:0]  sleep_mode_o,
  output logic             wdt_restart_o,
  output logic             break_o
);

  exec_state_t st_reg;
  exec_state_t st_next;
  op_t         op_reg;
  logic [4:0]  rd_reg;
  logic [4:0]  rs_reg;
  logic [2:0]  bit_reg;
  logic [1:0]  ncyc_reg;
  logic [15:0] ea_reg;
  logic [15:0] pnew_reg;
  logic [4:0]  pbase_reg;
  logic [7:0]  wd_reg;
  logic [7:0]  pmd_reg;
  logic [15:0] opnd_reg;
  logic [21:0] issue_reg;
  logic [15:0] sp_reg;
  logic [15:0] sp_next;
  logic [7:0]  stat_reg;
  logic [7:0]  stat_next;
  logic [2:0]  ctrl_reg;
  logic        rd_ack_reg;
  logic [31:0] rdata_reg;
  logic [7:0]  regs_q    [NREG];
  logic [7:0]  regs_next [NREG];

  bit_alu_if alu_bus ();

  bit_alu u_alu (
    .p (alu_bus.alu)
  );

  // Bus decode
  wire        busy     = (st_reg != ST_IDLE);
  wire        hit_opnd = (avs_address_i[7:2] == `OFS_OPERAND >> 2);
  wire        hit_iss  = (avs_address_i[7:2] == `OFS_ISSUE >> 2);
  wire        hit_st   = (avs_address_i[7:2] == `OFS_STATE >> 2);
  wire        hit_sp   = (avs_address_i[7:2] == `OFS_STACK >> 2);
  wire        hit_ctrl = (avs_address_i[7:2] == `OFS_CTRL >> 2);
  wire        hit_reg  = avs_address_i[`OFS_REGBIT];
  wire [4:0]  bus_ridx = avs_address_i[6:2];
  // Any write waits out a running instruction so software never races it
  wire        wr_ok    = avs_write_i & ~busy;
  wire        issue    = wr_ok & hit_iss;
  wire [31:0] bemask   = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                          {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  wire [31:0] wmerge_op = ({16'h0000, opnd_reg} & ~bemask) | (avs_writedata_i & bemask);
  wire [31:0] wmerge_sp = ({16'h0000, sp_reg} & ~bemask) | (avs_writedata_i & bemask);

  assign avs_waitrequest_o = (avs_read_i & ~rd_ack_reg) | (avs_write_i & busy);
  assign avs_readdata_o    = rdata_reg;

  wire [31:0] rd_mux =
      hit_reg  ? {24'h000000, regs_q[bus_ridx]} :
      hit_opnd ? {16'h0000, opnd_reg} :
      hit_iss  ? {10'h000, issue_reg} :
      hit_st   ? {23'h000000, busy, stat_reg} :
      hit_sp   ? {16'h0000, sp_reg} :
      hit_ctrl ? {29'h00000000, ctrl_reg} : 32'h00000000;

  // Fields of a new instruction as it is issued
  wire op_t   iop   = op_t'(avs_writedata_i[`ISS_OP_LSB +: 6]);
  wire [4:0]  irs   = avs_writedata_i[`ISS_RS_LSB +: 5];
  wire [1:0]  iptr  = avs_writedata_i[`ISS_PTR_LSB +: 2];
  wire        i_prd = (iop == OP_PRD0) | (iop == OP_PRD) | (iop == OP_PRDINC);
  wire        i_dsp = (iop == OP_LDQ) | (iop == OP_STD);
  // Displacement forms reach only Y or Z; program reads always use Z
  wire [1:0]  psel  = i_prd ? 2'd2 : (i_dsp ? ((iptr == 2'd2) ? 2'd2 : 2'd1) : iptr);
  wire [4:0]  pbase = `PTR_X_BASE + {2'b00, psel, 1'b0};
  wire [15:0] pcur  = {regs_q[pbase + 5'd1], regs_q[pbase]};
  wire [15:0] pinc  = pcur + 16'h0001;
  wire [15:0] pdec  = pcur - 16'h0001;

  logic [15:0] iea;
  logic [15:0] ipnew;
  logic [1:0]  incyc;

  always_comb begin
    iea   = pcur;
    ipnew = pcur;
    incyc = `CYC_ONE;
    case (iop)
      OP_LD, OP_ST: incyc = `CYC_MEM;
      OP_LDINC, OP_STINC: begin
        ipnew = pinc;
        incyc = `CYC_MEM;
      end
      OP_LDDEC, OP_STDEC: begin
        iea   = pdec;
        ipnew = pdec;
        incyc = `CYC_MEM;
      end
      OP_LDQ, OP_STD: begin
        iea   = pcur + {10'h000, opnd_reg[5:0]};
        incyc = `CYC_MEM;
      end
      OP_LDA, OP_STA: begin
        iea   = opnd_reg;
        incyc = `CYC_MEM;
      end
      OP_PRD0, OP_PRD: incyc = `CYC_PROG;
      OP_PRDINC: begin
        ipnew = pinc;
        incyc = `CYC_PROG;
      end
      OP_IN, OP_OUT: iea = opnd_reg;
      OP_PUSH: begin
        iea   = sp_reg;
        incyc = `CYC_MEM;
      end
      OP_POP: begin
        iea   = sp_reg + 16'h0001;
        incyc = `CYC_MEM;
      end
      default: incyc = `CYC_ONE;
    endcase
  end

  // Classes of the running instruction
  wire is_ld  = (op_reg == OP_LD) | (op_reg == OP_LDINC) | (op_reg == OP_LDDEC) |
                (op_reg == OP_LDQ) | (op_reg == OP_LDA) | (op_reg == OP_POP);
  wire is_st  = (op_reg == OP_ST) | (op_reg == OP_STINC) | (op_reg == OP_STDEC) |
                (op_reg == OP_STD) | (op_reg == OP_STA) | (op_reg == OP_PUSH);
  wire is_prd = (op_reg == OP_PRD0) | (op_reg == OP_PRD) | (op_reg == OP_PRDINC);
  wire p_upd  = (op_reg == OP_LDINC) | (op_reg == OP_LDDEC) | (op_reg == OP_STINC) |
                (op_reg == OP_STDEC) | (op_reg == OP_PRDINC);
  wire is_alu = (op_reg <= OP_MOV) & (op_reg != OP_NOP) | (op_reg == OP_IMM);
  wire ex1    = (st_reg == ST_EX1);
  wire last   = (ex1 & (ncyc_reg == `CYC_ONE)) | ((st_reg == ST_EX2) &
                (ncyc_reg == `CYC_MEM)) | (st_reg == ST_EX3);

  // Feed the shift and flag unit
  assign alu_bus.op       = op_reg;
  assign alu_bus.a        = (op_reg == OP_TSV) ? regs_q[rs_reg] : regs_q[rd_reg];
  assign alu_bus.b        = (op_reg == OP_IMM) ? opnd_reg[7:0] : regs_q[rs_reg];
  assign alu_bus.bidx     = bit_reg;
  assign alu_bus.flags_in = stat_reg;

  // Memory, I/O and control strobes
  assign dm_addr_o     = ea_reg;
  assign dm_wdata_o    = wd_reg;
  assign dm_re_o       = ex1 & is_ld;
  assign dm_we_o       = ex1 & is_st;
  assign pm_addr_o     = ea_reg;
  assign pm_re_o       = ex1 & is_prd;
  assign io_addr_o     = ea_reg[5:0];
  assign io_wdata_o    = wd_reg;
  assign io_re_o       = ex1 & (op_reg == OP_IN);
  assign io_we_o       = ex1 & (op_reg == OP_OUT);
  assign busy_o        = busy;
  assign sleep_req_o   = ex1 & (op_reg == OP_SLEEP) & ctrl_reg[`CTRL_SLP_EN];
  assign sleep_mode_o  = ctrl_reg[`CTRL_MODE_LSB +: 2];
  assign wdt_restart_o = ex1 & (op_reg == OP_WDG);
  assign break_o       = ex1 & (op_reg == OP_BRK);

  always_comb begin
    case (st_reg)
      ST_IDLE: st_next = issue ? ST_EX1 : ST_IDLE;
      ST_EX1:  st_next = (ncyc_reg == `CYC_ONE) ? ST_IDLE : ST_EX2;
      ST_EX2:  st_next = (ncyc_reg == `CYC_PROG) ? ST_EX3 : ST_IDLE;
      ST_EX3:  st_next = ST_IDLE;
      default: st_next = ST_IDLE;
    endcase
  end

  // Flags change only through the shift and flag unit or a bus write
  always_comb begin
    stat_next = stat_reg;
    if (wr_ok & hit_st & avs_byteenable_i[0]) begin
      stat_next = avs_writedata_i[7:0];
    end
    if (ex1 & is_alu) begin
      stat_next = alu_bus.flags_out;
    end
  end

  always_comb begin
    sp_next = sp_reg;
    if (wr_ok & hit_sp) begin
      sp_next = wmerge_sp[15:0];
    end
    if (last & (op_reg == OP_PUSH)) begin
      sp_next = sp_reg - 16'h0001;
    end
    if (last & (op_reg == OP_POP)) begin
      sp_next = sp_reg + 16'h0001;
    end
  end

  // Register file writes; a loaded byte wins over its own pointer update
  always_comb begin
    for (int k = 0; k < NREG; k++) begin
      regs_next[k] = regs_q[k];
    end
    if (wr_ok & hit_reg & avs_byteenable_i[0]) begin
      regs_next[bus_ridx] = avs_writedata_i[7:0];
    end
    if (ex1 & is_alu & (op_reg != OP_TSV) & (op_reg != OP_FSET) & (op_reg != OP_FCLR)) begin
      regs_next[rd_reg] = alu_bus.res;
    end
    if (ex1 & (op_reg == OP_WCPY)) begin
      regs_next[{rd_reg[4:1], 1'b0}] = regs_q[{rs_reg[4:1], 1'b0}];
      regs_next[{rd_reg[4:1], 1'b1}] = regs_q[{rs_reg[4:1], 1'b1}];
    end
    if (last & p_upd) begin
      regs_next[pbase_reg]        = pnew_reg[7:0];
      regs_next[pbase_reg + 5'd1] = pnew_reg[15:8];
    end
    if (ex1 & (op_reg == OP_IN)) begin
      regs_next[rd_reg] = io_rdata_i;
    end
    if (last & is_ld) begin
      regs_next[rd_reg] = dm_rdata_i;
    end
    if (last & is_prd) begin
      regs_next[(op_reg == OP_PRD0) ? 5'd0 : rd_reg] = pmd_reg;
    end
  end

  for (genvar i = 0; i < NREG; i++) begin : g_regs
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        regs_q[i] <= 8'h00;
      end else begin
        regs_q[i] <= regs_next[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg   <= ST_IDLE;
      stat_reg <= `RST_FLAGS;
      sp_reg   <= `RST_STACK;
      ctrl_reg <= `RST_CTRL;
      opnd_reg <= 16'h0000;
    end else begin
      st_reg   <= st_next;
      stat_reg <= stat_next;
      sp_reg   <= sp_next;
      if (wr_ok & hit_ctrl & avs_byteenable_i[0]) begin
        ctrl_reg <= avs_writedata_i[2:0];
      end
      if (wr_ok & hit_opnd) begin
        opnd_reg <= wmerge_op[15:0];
      end
    end
  end

  // Operands are captured once at issue and stay put while busy
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      op_reg    <= OP_NOP;
      rd_reg    <= 5'h00;
      rs_reg    <= 5'h00;
      bit_reg   <= 3'h0;
      ncyc_reg  <= `CYC_ONE;
      ea_reg    <= 16'h0000;
      pnew_reg  <= 16'h0000;
      pbase_reg <= 5'h00;
      wd_reg    <= 8'h00;
      issue_reg <= 22'h000000;
    end else if (issue) begin
      op_reg    <= iop;
      rd_reg    <= avs_writedata_i[`ISS_RD_LSB +: 5];
      rs_reg    <= irs;
      bit_reg   <= avs_writedata_i[`ISS_BIT_LSB +: 3];
      ncyc_reg  <= incyc;
      ea_reg    <= iea;
      pnew_reg  <= ipnew;
      pbase_reg <= pbase;
      wd_reg    <= regs_q[irs];
      issue_reg <= avs_writedata_i[21:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pmd_reg    <= 8'h00;
      rd_ack_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
    end else begin
      if ((st_reg == ST_EX2) & is_prd) begin
        pmd_reg <= pm_rdata_i;
      end
      rd_ack_reg <= avs_read_i & ~rd_ack_reg;
      if (avs_read_i & ~rd_ack_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

endmodule // core_exec

// [pkg/core_exec_params.svh]
// Constants for the bit, transfer and control execution unit.
// Assumes a 50 MHz core clock and byte-wide memories with one-cycle read latency.
`ifndef CORE_EXEC_PARAMS_SVH
`define CORE_EXEC_PARAMS_SVH

`define OFS_OPERAND   8'h00
`define OFS_ISSUE     8'h04
`define OFS_STATE     8'h08
`define OFS_STACK     8'h0c
`define OFS_CTRL      8'h10
`define OFS_REGBIT    7

`define ISS_OP_LSB    0
`define ISS_RD_LSB    6
`define ISS_RS_LSB    11
`define ISS_BIT_LSB   16
`define ISS_PTR_LSB   19
`define STATE_BUSY    8
`define CTRL_SLP_EN   0
`define CTRL_MODE_LSB 1

`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7

`define PTR_X_BASE    5'h1a
`define RST_STACK     16'h00ff
`define RST_FLAGS     8'h00
`define RST_CTRL      3'h0

`define CYC_ONE       2'h1
`define CYC_MEM       2'h2
`define CYC_PROG      2'h3

`endif

// [pkg/core_exec_pkg.sv]
// Types shared by the execution unit and its shift and flag unit.
// Assumes core_exec_params.svh supplies the numeric constants.
package core_exec_pkg;

  typedef enum logic [5:0] {
    OP_NOP  = 6'h00, OP_SHL  = 6'h01, OP_SHR  = 6'h02, OP_RCL  = 6'h03,
    OP_RCR  = 6'h04, OP_SAR  = 6'h05, OP_SWAP = 6'h06, OP_FSET = 6'h07,
    OP_FCLR = 6'h08, OP_TSV  = 6'h09, OP_TLD  = 6'h0a, OP_MOV  = 6'h0b,
    OP_WCPY = 6'h0c, OP_IMM  = 6'h0d, OP_LD   = 6'h0e, OP_LDINC = 6'h0f,
    OP_LDDEC = 6'h10, OP_LDQ = 6'h11, OP_ST   = 6'h12, OP_STINC = 6'h13,
    OP_STDEC = 6'h14, OP_STD = 6'h15, OP_LDA  = 6'h16, OP_STA  = 6'h17,
    OP_PRD0 = 6'h18, OP_PRD = 6'h19, OP_PRDINC = 6'h1a, OP_IN = 6'h1b,
    OP_OUT  = 6'h1c, OP_PUSH = 6'h1d, OP_POP  = 6'h1e, OP_SLEEP = 6'h1f,
    OP_WDG  = 6'h20, OP_BRK  = 6'h21
  } op_t;

  // Gray order along the busy path
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EX1  = 2'b01,
    ST_EX2  = 2'b11,
    ST_EX3  = 2'b10
  } exec_state_t;

endpackage

// [pkg/bit_alu_if.sv]
// Carries one operation between the execution unit and its shift and flag unit.
// Assumes both ends sit in the same clock domain; the path is combinational.
`timescale 1ns/1ns
interface bit_alu_if;
  import core_exec_pkg::*;
  op_t        op;
  logic [7:0] a;
  logic [7:0] b;
  logic [2:0] bidx;
  logic [7:0] flags_in;
  logic [7:0] res;
  logic [7:0] flags_out;
  modport core (output op, a, b, bidx, flags_in, input res, flags_out);
  modport alu  (input op, a, b, bidx, flags_in, output res, flags_out);
endinterface

// [design/bit_alu.sv]
// Shift, rotate, bit transfer and flag operations, purely combinational.
// Assumes the core applies res and flags_out only for the op it presents.
`timescale 1ns/1ns
`include "core_exec_params.svh"
module bit_alu
  import core_exec_pkg::*;
(
  // Operation in, result out
  bit_alu_if.alu p
);

  logic [7:0] r;
  logic       cy;
  logic       upd;
  logic [7:0] fo;

  always_comb begin
    r   = p.a;
    cy  = p.flags_in[`FLAG_C];
    upd = 1'b0;
    fo  = p.flags_in;
    case (p.op)
      OP_SHL: begin
        r   = {p.a[6:0], 1'b0};
        cy  = p.a[7];
        upd = 1'b1;
      end
      OP_SHR: begin
        r   = {1'b0, p.a[7:1]};
        cy  = p.a[0];
        upd = 1'b1;
      end
      OP_RCL: begin
        r   = {p.a[6:0], p.flags_in[`FLAG_C]};
        cy  = p.a[7];
        upd = 1'b1;
      end
      OP_RCR: begin
        r   = {p.flags_in[`FLAG_C], p.a[7:1]};
        cy  = p.a[0];
        upd = 1'b1;
      end
      OP_SAR: begin
        r   = {p.a[7], p.a[7:1]};
        cy  = p.a[0];
        upd = 1'b1;
      end
      OP_SWAP: r = {p.a[3:0], p.a[7:4]};
      OP_MOV, OP_IMM: r = p.b;
      OP_TLD: r[p.bidx] = p.flags_in[`FLAG_T];
      OP_TSV: fo[`FLAG_T] = p.a[p.bidx];
      OP_FSET: fo[p.bidx] = 1'b1;
      OP_FCLR: fo[p.bidx] = 1'b0;
      default: r = p.a;
    endcase
    if (upd) begin
      // Sign flag is left alone: only Z, C, N and V follow a shift
      fo[`FLAG_C] = cy;
      fo[`FLAG_Z] = (r == 8'h00);
      fo[`FLAG_N] = r[7];
      fo[`FLAG_V] = r[7] ^ cy;
    end
    p.res       = r;
    p.flags_out = fo;
  end

endmodule // bit_alu

// [test/core_exec_asserts.sv]
// Concurrent checks on bus handshake and instruction timing of core_exec.
// Assumes it is bound to core_exec and sees only that module's ports.
`timescale 1ns/1ns
module core_exec_asserts (
  // Clock and reset
  input wire logic       ref_clk_i,
  input wire logic       rstn_i,
  // Register bus
  input wire logic [7:0] avs_address_i,
  input wire logic       avs_read_i,
  input wire logic       avs_write_i,
  input wire logic       avs_waitrequest_o,
  // Strobes and status
  input wire logic       dm_re_o,
  input wire logic       dm_we_o,
  input wire logic       pm_re_o,
  input wire logic       io_re_o,
  input wire logic       io_we_o,
  input wire logic       busy_o,
  input wire logic       sleep_req_o,
  input wire logic       wdt_restart_o,
  input wire logic       break_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  // Length of the current busy run, so a stuck busy is caught early
  logic [2:0] run_len_reg;
  wire logic [2:0] run_len_next = busy_o ? run_len_reg + 3'h1 : 3'h0;
  wire logic       strobe_any = dm_re_o | dm_we_o | pm_re_o | io_re_o | io_we_o;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) run_len_reg <= 3'h0;
    else run_len_reg <= run_len_next;
  end

  sequence issue_taken_s;
    avs_write_i && !avs_waitrequest_o && avs_address_i[7:2] == 6'h01;
  endsequence
  sequence one_busy_s;
    $rose(busy_o) ##1 !busy_o;
  endsequence
  sequence two_busy_s;
    $rose(busy_o) ##1 busy_o ##1 !busy_o;
  endsequence
  sequence three_busy_s;
    $rose(busy_o) ##1 busy_o[*2] ##1 !busy_o;
  endsequence

  rd_wait_a:
    assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("read answer not in second cycle");
  wr_stall_a:
    assert property (avs_write_i && busy_o |-> avs_waitrequest_o)
    else $error("write accepted while busy");
  wr_idle_a:
    assert property (avs_write_i && !busy_o |-> !avs_waitrequest_o)
    else $error("write stalled while idle");
  issue_start_a:
    assert property (issue_taken_s |=> $rose(busy_o))
    else $error("accepted issue did not start execution");
  mem_len_a:
    assert property ((dm_re_o || dm_we_o) |-> two_busy_s)
    else $error("data memory access not two cycles");
  prog_len_a:
    assert property (pm_re_o |-> three_busy_s)
    else $error("program memory read not three cycles");
  io_len_a:
    assert property ((io_re_o || io_we_o) |-> one_busy_s)
    else $error("io access not one cycle");
  ctl_len_a:
    assert property ((sleep_req_o || wdt_restart_o || break_o) |-> one_busy_s)
    else $error("control pulse not in a one cycle run");
  busy_max_a:
    assert property (busy_o |-> run_len_reg < 3'h3)
    else $error("busy longer than three cycles");
  strobe_one_a:
    assert property (strobe_any |=> !strobe_any)
    else $error("memory strobe longer than one cycle");
endmodule // core_exec_asserts

bind core_exec core_exec_asserts u_asserts (
  .ref_clk_i, .rstn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o,
  .dm_re_o, .dm_we_o, .pm_re_o, .io_re_o, .io_we_o, .busy_o, .sleep_req_o,
  .wdt_restart_o, .break_o
);

// [test/mem_io_model.sv]
// Data memory, program memory and I/O space behind the execution unit.
// Assumes one-cycle memory read latency and same-cycle I/O reads.
`timescale 1ns/1ns
module mem_io_model (
  // Clock
  input  wire logic        clk_i,
  // Data memory
  input  wire logic [15:0] dm_addr_i,
  input  wire logic [7:0]  dm_wdata_i,
  input  wire logic        dm_re_i,
  input  wire logic        dm_we_i,
  output logic      [7:0]  dm_rdata_o,
  // Program memory
  input  wire logic [15:0] pm_addr_i,
  input  wire logic        pm_re_i,
  output logic      [7:0]  pm_rdata_o,
  // I/O space
  input  wire logic [5:0]  io_addr_i,
  input  wire logic [7:0]  io_wdata_i,
  input  wire logic        io_re_i,
  input  wire logic        io_we_i,
  output logic      [7:0]  io_rdata_o
);
  logic [7:0] dm [0:65535];
  logic [7:0] io [0:63];
  logic [7:0] dq = 8'h00;
  logic [7:0] pq = 8'h00;
  logic       dv = 1'b0;
  logic       pv = 1'b0;
  initial begin
    for (int i = 0; i < 65536; i++) dm[i] = 8'(i) ^ 8'(i >> 8) ^ 8'ha5;
    for (int i = 0; i < 64; i++) io[i] = 8'(i) | 8'h40;
  end
  // Read data shows only in its valid cycle; inverted otherwise to expose late sampling
  assign dm_rdata_o = dv ? dq : ~dq;
  assign pm_rdata_o = pv ? pq : ~pq;
  assign io_rdata_o = io_re_i ? io[io_addr_i] : ~io[io_addr_i];
  always @(posedge clk_i) begin
    dv <= dm_re_i;
    pv <= pm_re_i;
    if (dm_re_i) dq <= dm[dm_addr_i];
    if (pm_re_i) pq <= ~(pm_addr_i[7:0] ^ pm_addr_i[15:8]);
    if (dm_we_i) dm[dm_addr_i] <= dm_wdata_i;
    if (io_we_i) io[io_addr_i] <= io_wdata_i;
  end
endmodule // mem_io_model

// [test/core_exec_tb.sv]
// Self-checking bench for core_exec: issues instructions over Avalon-MM.
// Assumes mem_io_model contents: data a^(a>>8)^a5, program ~(a^(a>>8)), io a|40.
`timescale 1ns/1ns
module core_exec_tb
  import core_exec_pkg::*;
();
  logic        ref_clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [7:0]  avs_address_i = 8'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic [15:0] dm_addr_o, pm_addr_o;
  logic [7:0]  dm_wdata_o, dm_rdata_i, pm_rdata_i, io_wdata_o, io_rdata_i;
  logic [5:0]  io_addr_o;
  logic [1:0]  sleep_mode_o;
  logic        avs_waitrequest_o, dm_re_o, dm_we_o, pm_re_o, io_re_o, io_we_o;
  logic        busy_o, sleep_req_o, wdt_restart_o, break_o;
  int          err_total = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          n_slp = 0;
  int          n_wdt = 0;
  int          n_brk = 0;
  op_t         sops[5] = '{OP_SHL, OP_SHR, OP_RCL, OP_RCR, OP_SAR};
  logic [7:0]  vals[2] = '{8'h81, 8'h01};

  core_exec #(.NREG(32)) DUT (.ref_clk_i, .rstn_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o,
    .avs_waitrequest_o, .dm_addr_o, .dm_wdata_o, .dm_re_o, .dm_we_o, .dm_rdata_i,
    .pm_addr_o, .pm_re_o, .pm_rdata_i, .io_addr_o, .io_wdata_o, .io_re_o, .io_we_o,
    .io_rdata_i, .busy_o, .sleep_req_o, .sleep_mode_o, .wdt_restart_o, .break_o);
  mem_io_model mdl (.clk_i(ref_clk_i), .dm_addr_i(dm_addr_o), .dm_wdata_i(dm_wdata_o),
    .dm_re_i(dm_re_o), .dm_we_i(dm_we_o), .dm_rdata_o(dm_rdata_i), .pm_addr_i(pm_addr_o),
    .pm_re_i(pm_re_o), .pm_rdata_o(pm_rdata_i), .io_addr_i(io_addr_o),
    .io_wdata_i(io_wdata_o), .io_re_i(io_re_o), .io_we_i(io_we_o), .io_rdata_o(io_rdata_i));

  always #10 ref_clk_i = ~ref_clk_i;
  // Run takes about 600 cycles; the ceiling leaves ample margin
  always @(posedge ref_clk_i) begin
    cyc++;
    if (sleep_req_o === 1'b1) n_slp++;
    if (wdt_restart_o === 1'b1) n_wdt++;
    if (break_o === 1'b1) n_brk++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict;
    end
  end

  task automatic print_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic av_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= 1'b1;
    @(posedge ref_clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge ref_clk_i);
    avs_write_i <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    @(posedge ref_clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge ref_clk_i);
    d = avs_readdata_o;
    avs_read_i <= 1'b0;
    chk(d, e);
  endtask
  task automatic setr(input int n, input logic [7:0] v);
    av_wr(8'h80 + 8'(4 * n), {24'h0, v});
  endtask
  task automatic ckr(input int n, input logic [7:0] e);
    rdc(8'h80 + 8'(4 * n), {24'h0, e});
  endtask
  task automatic setp(input int p, input logic [15:0] v);
    setr(26 + 2 * p, v[7:0]);
    setr(27 + 2 * p, v[15:8]);
  endtask
  task automatic ckp(input int p, input logic [15:0] v);
    ckr(26 + 2 * p, v[7:0]);
    ckr(27 + 2 * p, v[15:8]);
  endtask
  task automatic cm(input logic [15:0] a, input logic [7:0] e);
    chk({24'h0, mdl.dm[a]}, {24'h0, e});
  endtask
  // Issues one instruction and checks how many cycles busy stays up
  task automatic run(input op_t o, input int rd, input int rs, input int b, input int p,
                     input int nc);
    int n;
    av_wr(8'h04, {11'h0, 2'(p), 3'(b), 5'(rs), 5'(rd), o});
    n = 0;
    @(negedge ref_clk_i);
    while (busy_o === 1'b1) begin
      n++;
      @(negedge ref_clk_i);
    end
    chk(32'(n), 32'(nc));
  endtask
  function automatic logic [7:0] dmv(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'ha5;
  endfunction
  function automatic logic [7:0] pmv(input logic [15:0] a);
    return ~(a[7:0] ^ a[15:8]);
  endfunction
  // Expected {carry, result} of a shift or rotate
  function automatic logic [8:0] shx(input op_t o, input logic [7:0] a, input logic c);
    case (o)
      OP_SHL: return {a[7], a[6:0], 1'b0};
      OP_SHR: return {a[0], 1'b0, a[7:1]};
      OP_RCL: return {a[7], a[6:0], c};
      OP_RCR: return {a[0], c, a[7:1]};
      default: return {a[0], a[7], a[7:1]};
    endcase
  endfunction

  initial begin
    logic [8:0] e;
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rdc(8'h08, 32'h0);
    rdc(8'h0c, 32'hff);
    rdc(8'h40, 32'h0);
    foreach (sops[i]) foreach (vals[j]) begin
      av_wr(8'h08, 32'h70 | 32'(j));
      setr(16, vals[j]);
      run(sops[i], 16, 0, 0, 0, 1);
      e = shx(sops[i], vals[j], 1'(j));
      ckr(16, e[7:0]);
      rdc(8'h08, {24'h7, e[7] ^ e[8], e[7], e[7:0] == 8'h0, e[8]});
    end
    for (int i = 0; i < 8; i++) begin
      av_wr(8'h08, 32'h0);
      run(OP_FSET, 0, 0, i, 0, 1);
      rdc(8'h08, {24'h0, 8'h01 << i});
      av_wr(8'h08, 32'hff);
      run(OP_FCLR, 0, 0, i, 0, 1);
      rdc(8'h08, {24'h0, ~(8'h01 << i)});
    end
    setr(20, 8'h20);
    av_wr(8'h08, 32'h0);
    run(OP_TSV, 0, 20, 5, 0, 1);
    rdc(8'h08, 32'h40);
    av_wr(8'h08, 32'hff);
    run(OP_TSV, 0, 20, 4, 0, 1);
    rdc(8'h08, 32'hbf);
    av_wr(8'h08, 32'h40);
    setr(21, 8'hf0);
    run(OP_TLD, 21, 0, 3, 0, 1);
    ckr(21, 8'hf8);
    av_wr(8'h08, 32'h1a);
    run(OP_TLD, 21, 0, 7, 0, 1);
    ckr(21, 8'h78);
    av_wr(8'h00, 32'hbeef);
    run(OP_IMM, 17, 0, 0, 0, 1);
    run(OP_SWAP, 17, 0, 0, 0, 1);
    ckr(17, 8'hfe);
    setr(19, 8'h33);
    run(OP_MOV, 18, 17, 0, 0, 1);
    run(OP_WCPY, 2, 18, 0, 0, 1);
    ckr(2, 8'hfe);
    ckr(3, 8'h33);
    run(OP_NOP, 0, 0, 0, 0, 1);
    rdc(8'h08, 32'h1a);
    setp(0, 16'h0120);
    setp(1, 16'h0200);
    setp(2, 16'h0300);
    run(OP_LD, 1, 0, 0, 0, 2);
    ckr(1, dmv(16'h0120));
    run(OP_LDINC, 2, 0, 0, 1, 2);
    ckr(2, dmv(16'h0200));
    ckp(1, 16'h0201);
    run(OP_LDDEC, 3, 0, 0, 2, 2);
    ckr(3, dmv(16'h02ff));
    av_wr(8'h00, 32'h3f);
    run(OP_LDQ, 4, 0, 0, 2, 2);
    ckr(4, dmv(16'h033e));
    ckp(2, 16'h02ff);
    av_wr(8'h00, 32'h1456);
    run(OP_LDA, 5, 0, 0, 0, 2);
    ckr(5, dmv(16'h1456));
    setr(8, 8'hc3);
    run(OP_ST, 0, 8, 0, 0, 2);
    cm(16'h0120, 8'hc3);
    ckp(0, 16'h0120);
    run(OP_STINC, 0, 8, 0, 2, 2);
    cm(16'h02ff, 8'hc3);
    ckp(2, 16'h0300);
    run(OP_STDEC, 0, 8, 0, 1, 2);
    cm(16'h0200, 8'hc3);
    ckp(1, 16'h0200);
    run(OP_STD, 0, 8, 0, 1, 2);
    cm(16'h0216, 8'hc3);
    ckp(1, 16'h0200);
    run(OP_STA, 0, 8, 0, 0, 2);
    cm(16'h1456, 8'hc3);
    setp(2, 16'h12ff);
    run(OP_PRD0, 9, 0, 0, 2, 3);
    ckr(0, pmv(16'h12ff));
    run(OP_PRD, 9, 0, 0, 2, 3);
    ckr(9, pmv(16'h12ff));
    run(OP_PRDINC, 10, 0, 0, 2, 3);
    ckr(10, pmv(16'h12ff));
    ckp(2, 16'h1300);
    av_wr(8'h00, 32'h2a);
    run(OP_OUT, 0, 8, 0, 0, 1);
    chk({24'h0, mdl.io[6'h2a]}, 32'hc3);
    av_wr(8'h00, 32'h15);
    run(OP_IN, 11, 0, 0, 0, 1);
    ckr(11, 8'h55);
    run(OP_PUSH, 0, 8, 0, 0, 2);
    cm(16'h00ff, 8'hc3);
    rdc(8'h0c, 32'hfe);
    run(OP_POP, 12, 0, 0, 0, 2);
    ckr(12, 8'hc3);
    rdc(8'h0c, 32'hff);
    av_wr(8'h10, 32'h5);
    run(OP_SLEEP, 0, 0, 0, 0, 1);
    chk({30'h0, sleep_mode_o}, 32'h2);
    run(OP_WDG, 0, 0, 0, 0, 1);
    run(OP_BRK, 0, 0, 0, 0, 1);
    av_wr(8'h10, 32'h0);
    run(OP_SLEEP, 0, 0, 0, 0, 1);
    chk(32'(n_slp + 10 * n_wdt + 100 * n_brk), 32'd111);
    rdc(8'h08, 32'h1a);
    // Second issue lands while the load is busy and must wait, not be lost
    av_wr(8'h04, {21'h0, 5'd13, OP_LDA});
    run(OP_NOP, 0, 0, 0, 0, 1);
    ckr(13, dmv(16'h0015));
    print_verdict;
  end
endmodule // core_exec_tb
